// ### logic/jom_pkg.sv
/*
 * Shared constants, types and the link-mode decoder of the transport-layer
 * octet mapper. Assumes the link mode code is stable for whole frames.
 */
package jom_pkg;

    // Widths and counts of the frame.
    localparam int SAMP_W    = 12;
    localparam int DDC_W     = 15;
    localparam int LANE_W    = 16;
    localparam int MAX_LANES = 8;
    localparam int N_SAMP    = 16;
    localparam int MODE_W    = 7;

    // Offset-binary code of zero input, centre of the overrange compare.
    localparam logic [11:0] MID_CODE  = 12'h800;
    // Octets per lane and frame.
    localparam logic [1:0]  OCT_ONE   = 2'h1;
    localparam logic [1:0]  OCT_TWO   = 2'h2;
    // Reset value of the mapped lanes.
    localparam logic [15:0] LANE_RST  = 16'h0000;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_BYP12_S,
        KIND_BYP12_D,
        KIND_BYP8_S,
        KIND_BYP8_D,
        KIND_DDC_S,
        KIND_DDC_D
    } jom_kind_e;

    typedef struct packed {
        jom_kind_e   kind;
        logic [3:0]  lanes;       // Lanes used on each link.
        logic        shared_flag; // One overrange flag per two samples.
        logic        ok;
    } jom_cfg_s;

    // Turns a link mode code into its layout; unknown codes are not ok.
    function automatic jom_cfg_s jom_decode(input logic [6:0] code);
        jom_cfg_s c;
        c = '{kind: KIND_NONE, lanes: 4'h0, shared_flag: 1'b0, ok: 1'b0};
        case (code)
            7'h13, 7'h2A: c = '{KIND_BYP12_S, 4'h6, 1'b0, 1'b1};
            7'h14, 7'h2B: c = '{KIND_BYP12_D, 4'h6, 1'b0, 1'b1};
            7'h20:        c = '{KIND_BYP12_S, 4'h3, 1'b0, 1'b1};
            7'h21:        c = '{KIND_BYP12_D, 4'h3, 1'b0, 1'b1};
            7'h22:        c = '{KIND_BYP8_S,  4'h2, 1'b0, 1'b1};
            7'h23:        c = '{KIND_BYP8_D,  4'h2, 1'b0, 1'b1};
            7'h15, 7'h24: c = '{KIND_DDC_S,   4'h2, 1'b0, 1'b1};
            7'h16, 7'h2E: c = '{KIND_DDC_S,   4'h4, 1'b0, 1'b1};
            7'h17, 7'h26, 7'h3D, 7'h40, 7'h45, 7'h47:
                          c = '{KIND_DDC_S,   4'h1, 1'b0, 1'b1};
            7'h18, 7'h30, 7'h3E, 7'h41, 7'h46:
                          c = '{KIND_DDC_S,   4'h2, 1'b0, 1'b1};
            7'h19, 7'h34: c = '{KIND_DDC_S,   4'h8, 1'b1, 1'b1};
            7'h1A, 7'h36, 7'h3F:
                          c = '{KIND_DDC_S,   4'h4, 1'b0, 1'b1};
            7'h1B:        c = '{KIND_DDC_S,   4'h8, 1'b0, 1'b1};
            7'h25:        c = '{KIND_DDC_D,   4'h2, 1'b0, 1'b1};
            default:      c = '{KIND_NONE,    4'h0, 1'b0, 1'b0};
        endcase
        return c;
    endfunction : jom_decode

endpackage : jom_pkg

// ### logic/jom_ovr_if.sv
/*
 * Carrier between the mapper and its overrange detector.
 * Assumes both ends sit on the same frame clock.
 */
`timescale 1ns/10ps
interface jom_ovr_if;
    logic [7:0][11:0] samp_a;
    logic [7:0][11:0] samp_b;
    logic [11:0]      thresh;
    logic [7:0]       flag_a;
    logic [7:0]       flag_b;

    modport det (input samp_a, input samp_b, input thresh,
                 output flag_a, output flag_b);
    modport map (output samp_a, output samp_b, output thresh,
                 input flag_a, input flag_b);
endinterface : jom_ovr_if

// ### logic/jom_ovr_detect.sv
/*
 * Overrange detector: compares the distance of each offset-binary sample
 * from mid-scale with the threshold. Purely combinational; the mapper
 * registers the flags together with the data they belong to.
 */
`timescale 1ns/10ps
module jom_ovr_detect (
    input wire logic clk,
    input wire logic rstn,
    jom_ovr_if.det   ovr
);
    // Magnitude compare per sample; equal to the threshold is not over.
    always_comb begin
        logic [11:0] ma;
        logic [11:0] mb;
        ma = '0;
        mb = '0;
        for (int k = 0; k < 8; k++) begin
            ma = (ovr.samp_a[k] >= jom_pkg::MID_CODE) ?
                 ovr.samp_a[k] - jom_pkg::MID_CODE :
                 jom_pkg::MID_CODE - ovr.samp_a[k];
            mb = (ovr.samp_b[k] >= jom_pkg::MID_CODE) ?
                 ovr.samp_b[k] - jom_pkg::MID_CODE :
                 jom_pkg::MID_CODE - ovr.samp_b[k];
            ovr.flag_a[k] = ma > ovr.thresh;
            ovr.flag_b[k] = mb > ovr.thresh;
        end
    end

    // Full-scale low code must always flag against a small threshold.
    chk_ovr_low_code: assert property (@(posedge clk) disable iff (!rstn)
        (ovr.samp_a[0] == 12'h000 && ovr.thresh < 12'h7FF)
        |-> ovr.flag_a[0])
        else $error("low code did not raise overrange");
endmodule : jom_ovr_detect

// ### logic/jom_octet_mapper.sv
/*
 * Transport-layer octet mapper: places one frame of samples or I/Q words
 * with overrange flags onto the lanes of links A and B.
 * Assumes all inputs come from logic on the frame clock and hold one
 * frame per cycle while frame_valid is high.
 */
// Behaviour
// - Mode 19: even samples on link A lanes 0-5, odd on link B.
// - Three lanes hold four 12-bit samples, second and third split.
// - Modes 20/43: channel A on link A lanes 0-5, channel B on B.
// - Mode 21: I words with I flags on A, Q on B, two lanes.
// - Modes 22/46: I 0-3 on A lanes 0-3, Q 0-3 on B.
// - Mode 23 family: I 0 on A lane 0, Q 0 on B lane 0.
// - Mode 24 family: I 0-1 on A, Q 0-1 on B, own flags.
// - Modes 25/52: eight lanes per link, flag k shared by 2k, 2k+1.
// - Modes 26/54/63: I 0-3 on A, Q 0-3 on B, own flags.
// - Mode 27: I 0-7 on A, Q 0-7 on B, own flags.
// - Mode 32: even samples 0-6 on A lanes 0-2, odd on B.
// - Mode 33: channel A 0-3 on A lanes 0-2, channel B on B.
// - Mode 34: one octet, A carries samples 0,2, B carries 1,3.
// - Mode 35: one octet, A carries channel A 0-1, B channel B.
// - Mode 37: I word on lane 0, Q word on lane 1 per channel.
// - Bypass uses 12-bit samples, 8-bit in modes 34/35; decimated words are 15 bits plus flag.
// - Most significant bit first; unused bits and lanes are zero.
// - Overrange flag high when sample distance from mid-scale exceeds the threshold.
`timescale 1ns/10ps
module jom_octet_mapper (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [6:0]        link_mode_code,
    input  wire logic              frame_valid,
    input  wire logic [15:0][11:0] samp,
    input  wire logic [7:0][14:0]  i_word,
    input  wire logic [7:0][14:0]  q_word,
    input  wire logic [7:0][11:0]  ovr_samp_a,
    input  wire logic [7:0][11:0]  ovr_samp_b,
    input  wire logic [11:0]       ovr_thresh,
    output logic [7:0][15:0]       link_a_lane,
    output logic [7:0][15:0]       link_b_lane,
    output logic                   lane_valid,
    output logic [3:0]             lanes_used,
    output logic [1:0]             octets_per_lane,
    output logic                   mode_bad
);
    typedef struct packed {
        logic [7:0][15:0] la;
        logic [7:0][15:0] lb;
        logic             valid;
        logic [3:0]       lanes;
        logic [1:0]       octets;
        logic             bad;
    } jom_state_s;

    jom_state_s        st_q;
    jom_state_s        st_d;
    jom_pkg::jom_cfg_s cfg;
    jom_ovr_if         ovr ();

    assign cfg        = jom_pkg::jom_decode(link_mode_code);
    assign ovr.samp_a = ovr_samp_a;
    assign ovr.samp_b = ovr_samp_b;
    assign ovr.thresh = ovr_thresh;

    jom_ovr_detect u_ovr (
        .clk  (clk),
        .rstn (rstn),
        .ovr  (ovr)
    );

    // Builds the next frame. Lanes are cleared first so that every lane
    // or bit that a mode leaves unused goes out as zero.
    always_comb begin
        logic [47:0] ga;
        logic [47:0] gb;
        int          fi;
        ga = '0;
        gb = '0;
        fi = 0;
        st_d = st_q;
        st_d.valid = frame_valid & cfg.ok;
        if (frame_valid) begin
            st_d.la = '0;
            st_d.lb = '0;
            st_d.lanes = cfg.lanes;
            st_d.bad = ~cfg.ok;
            st_d.octets = jom_pkg::OCT_TWO;
            case (cfg.kind)
                jom_pkg::KIND_BYP12_S: begin
                    for (int g = 0; g < 2; g++) begin
                        // Even samples to A, odd to B, four per group.
                        ga = {samp[8*g], samp[8*g+2],
                              samp[8*g+4], samp[8*g+6]};
                        gb = {samp[8*g+1], samp[8*g+3],
                              samp[8*g+5], samp[8*g+7]};
                        if (3 * g < int'(cfg.lanes)) begin
                            st_d.la[3*g]   = ga[47:32];
                            st_d.la[3*g+1] = ga[31:16];
                            st_d.la[3*g+2] = ga[15:0];
                            st_d.lb[3*g]   = gb[47:32];
                            st_d.lb[3*g+1] = gb[31:16];
                            st_d.lb[3*g+2] = gb[15:0];
                        end
                    end
                end
                jom_pkg::KIND_BYP12_D: begin
                    for (int g = 0; g < 2; g++) begin
                        // Channel A is samp 0-7, channel B samp 8-15.
                        ga = {samp[4*g], samp[4*g+1],
                              samp[4*g+2], samp[4*g+3]};
                        gb = {samp[8+4*g], samp[8+4*g+1],
                              samp[8+4*g+2], samp[8+4*g+3]};
                        if (3 * g < int'(cfg.lanes)) begin
                            st_d.la[3*g]   = ga[47:32];
                            st_d.la[3*g+1] = ga[31:16];
                            st_d.la[3*g+2] = ga[15:0];
                            st_d.lb[3*g]   = gb[47:32];
                            st_d.lb[3*g+1] = gb[31:16];
                            st_d.lb[3*g+2] = gb[15:0];
                        end
                    end
                end
                jom_pkg::KIND_BYP8_S: begin
                    // The 8-bit sample is the top of the 12-bit code.
                    st_d.octets = jom_pkg::OCT_ONE;
                    st_d.la[0] = {samp[0][11:4], 8'h00};
                    st_d.la[1] = {samp[2][11:4], 8'h00};
                    st_d.lb[0] = {samp[1][11:4], 8'h00};
                    st_d.lb[1] = {samp[3][11:4], 8'h00};
                end
                jom_pkg::KIND_BYP8_D: begin
                    st_d.octets = jom_pkg::OCT_ONE;
                    st_d.la[0] = {samp[0][11:4], 8'h00};
                    st_d.la[1] = {samp[1][11:4], 8'h00};
                    st_d.lb[0] = {samp[8][11:4], 8'h00};
                    st_d.lb[1] = {samp[9][11:4], 8'h00};
                end
                jom_pkg::KIND_DDC_S: begin
                    // One word per lane; the flag index halves when shared.
                    for (int k = 0; k < 8; k++) begin
                        fi = cfg.shared_flag ? k / 2 : k;
                        if (k < int'(cfg.lanes)) begin
                            st_d.la[k] = {i_word[k],
                                          ovr.flag_a[fi]};
                            st_d.lb[k] = {q_word[k],
                                          ovr.flag_b[fi]};
                        end
                    end
                end
                jom_pkg::KIND_DDC_D: begin
                    st_d.la[0] = {i_word[0], ovr.flag_a[0]};
                    st_d.la[1] = {q_word[0], ovr.flag_a[1]};
                    st_d.lb[0] = {i_word[1], ovr.flag_b[0]};
                    st_d.lb[1] = {q_word[1], ovr.flag_b[1]};
                end
                default: begin
                    st_d.octets = jom_pkg::OCT_TWO;
                end
            endcase
        end
    end

    // One register stage; a frame appears one edge after it is offered.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q.la     <= {8{jom_pkg::LANE_RST}};
            st_q.lb     <= {8{jom_pkg::LANE_RST}};
            st_q.valid  <= 1'b0;
            st_q.lanes  <= 4'h0;
            st_q.octets <= jom_pkg::OCT_TWO;
            st_q.bad    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link_a_lane     = st_q.la;
    assign link_b_lane     = st_q.lb;
    assign lane_valid      = st_q.valid;
    assign lanes_used      = st_q.lanes;
    assign octets_per_lane = st_q.octets;
    assign mode_bad        = st_q.bad;

    sequence s_frame(logic [6:0] code);
        frame_valid && link_mode_code == code;
    endsequence

    chk_byp12_first_lane: assert property (@(posedge clk) disable iff (!rstn)
        s_frame(7'h13) |=> link_a_lane[0] ==
            {$past(samp[0]), $past(samp[2][11:8])})
        else $error("mode 19 lane A0 wrong");
    chk_byp12_split: assert property (@(posedge clk) disable iff (!rstn)
        s_frame(7'h20) |=> link_a_lane[1] ==
            {$past(samp[2][7:0]), $past(samp[4][11:4])})
        else $error("12-bit split sample wrong");
    chk_dual12_link_b: assert property (@(posedge clk) disable iff (!rstn)
        s_frame(7'h14) |=> link_b_lane[5] ==
            {$past(samp[14][3:0]), $past(samp[15])})
        else $error("mode 20 lane B5 wrong");
    chk_ddc4_q_lane: assert property (@(posedge clk) disable iff (!rstn)
        s_frame(7'h15) |=> link_b_lane[1] ==
            {$past(q_word[1]), $past(ovr.flag_b[1])})
        else $error("mode 21 lane B1 wrong");
    chk_ddc_shared_flag: assert property (@(posedge clk) disable iff (!rstn)
        s_frame(7'h19) |=> link_a_lane[3] ==
            {$past(i_word[3]), $past(ovr.flag_a[1])})
        else $error("shared overrange flag wrong");
    chk_oct8_sample: assert property (@(posedge clk) disable iff (!rstn)
        s_frame(7'h22) |=> link_a_lane[1] == {$past(samp[2][11:4]), 8'h00}
            && octets_per_lane == jom_pkg::OCT_ONE)
        else $error("mode 34 lane A1 wrong");
    chk_dual_ddc_q: assert property (@(posedge clk) disable iff (!rstn)
        s_frame(7'h25) |=> link_a_lane[1] ==
            {$past(q_word[0]), $past(ovr.flag_a[1])})
        else $error("mode 37 lane A1 wrong");
    chk_unused_lane_zero: assert property (@(posedge clk) disable iff (!rstn)
        frame_valid && cfg.lanes < 4'h8 |=> link_a_lane[7] == 16'h0000
            && link_b_lane[7] == 16'h0000)
        else $error("unused lane not zero");
    chk_valid_follows: assert property (@(posedge clk) disable iff (!rstn)
        frame_valid |=> lane_valid == !mode_bad ##1 $past(frame_valid)
            || !lane_valid)
        else $error("lane valid out of step");
endmodule : jom_octet_mapper

// ### dv/jom_rx_model.sv
/*
 * Receiving-side model that rebuilds 12-bit single-channel samples.
 * Assumes the registered lanes of the mapper on one frame clock.
 */
`timescale 1ns/10ps
module jom_rx_model (
    input  wire logic              lane_valid,
    input  wire logic [7:0][15:0]  link_a_lane,
    input  wire logic [7:0][15:0]  link_b_lane,
    input  wire logic [3:0]        lanes_used,
    output logic      [15:0][11:0] rx_samp
);
    // Each three-lane group yields four samples; link A even, link B odd.
    always_comb begin
        logic [47:0] wa;
        logic [47:0] wb;
        wa = '0;
        wb = '0;
        rx_samp = '0;
        for (int g = 0; g < 2; g++) begin
            wa = {link_a_lane[3*g], link_a_lane[3*g+1], link_a_lane[3*g+2]};
            wb = {link_b_lane[3*g], link_b_lane[3*g+1], link_b_lane[3*g+2]};
            if (lane_valid && 3 * g < lanes_used) begin
                for (int k = 0; k < 4; k++) begin
                    rx_samp[8*g+2*k]   = wa[47-12*k -: 12];
                    rx_samp[8*g+2*k+1] = wb[47-12*k -: 12];
                end
            end
        end
    end
endmodule : jom_rx_model

// ### dv/tb.sv
/*
 * Self-checking bench of the octet mapper: frames of every mode code,
 * predicted lanes kept in a queue and compared as results appear.
 * Assumes the package and design under logic/ are compiled first.
 */
`timescale 1ns/10ps
module tb;
    typedef struct packed {
        logic [7:0][15:0]  a;
        logic [7:0][15:0]  b;
        logic [15:0][11:0] s;
        logic [7:0]        st;
        logic              rx;
    } jom_tb_exp_s;

    logic              clk;
    logic              rstn;
    logic [6:0]        link_mode_code;
    logic              frame_valid;
    logic [15:0][11:0] samp;
    logic [7:0][14:0]  i_word;
    logic [7:0][14:0]  q_word;
    logic [7:0][11:0]  ovr_samp_a;
    logic [7:0][11:0]  ovr_samp_b;
    logic [11:0]       ovr_thresh;
    logic [7:0][15:0]  link_a_lane;
    logic [7:0][15:0]  link_b_lane;
    logic              lane_valid;
    logic [3:0]        lanes_used;
    logic [1:0]        octets_per_lane;
    logic              mode_bad;
    logic [15:0][11:0] rx_samp;
    logic              fv_d;
    int                n_mismatch;
    int                n_checks;
    jom_tb_exp_s       exp_q[$];
    // Code, layout kind, lanes per link; kind 7 shares one flag per pair.
    int mt[32][3] = '{
        '{19, 1, 6}, '{42, 1, 6}, '{20, 2, 6}, '{43, 2, 6},
        '{32, 1, 3}, '{33, 2, 3}, '{34, 3, 2}, '{35, 4, 2},
        '{21, 5, 2}, '{36, 5, 2}, '{22, 5, 4}, '{46, 5, 4},
        '{23, 5, 1}, '{38, 5, 1}, '{61, 5, 1}, '{64, 5, 1},
        '{69, 5, 1}, '{71, 5, 1}, '{24, 5, 2}, '{48, 5, 2},
        '{62, 5, 2}, '{65, 5, 2}, '{70, 5, 2}, '{25, 7, 8},
        '{52, 7, 8}, '{26, 5, 4}, '{54, 5, 4}, '{63, 5, 4},
        '{27, 5, 8}, '{37, 6, 2}, '{0, 0, 0}, '{127, 0, 0}
    };

    jom_octet_mapper uut (
        .clk(clk), .rstn(rstn), .link_mode_code(link_mode_code),
        .frame_valid(frame_valid), .samp(samp), .i_word(i_word),
        .q_word(q_word), .ovr_samp_a(ovr_samp_a), .ovr_samp_b(ovr_samp_b),
        .ovr_thresh(ovr_thresh), .link_a_lane(link_a_lane),
        .link_b_lane(link_b_lane), .lane_valid(lane_valid),
        .lanes_used(lanes_used), .octets_per_lane(octets_per_lane),
        .mode_bad(mode_bad)
    );
    jom_rx_model rx (
        .lane_valid(lane_valid), .link_a_lane(link_a_lane),
        .link_b_lane(link_b_lane), .lanes_used(lanes_used),
        .rx_samp(rx_samp)
    );

    task automatic cmp_lanes(input logic [127:0] g, input logic [127:0] x);
        n_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, g, x);
        end
    endtask : cmp_lanes
    task automatic cmp_stat(input logic [7:0] g, input logic [7:0] x);
        n_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, g, x);
        end
    endtask : cmp_stat
    task automatic cmp_samp(input logic [191:0] g, input logic [191:0] x);
        n_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, g, x);
        end
    endtask : cmp_samp

    // Distance from mid-scale must strictly exceed the threshold.
    function automatic logic ovf(input logic [11:0] s);
        logic [11:0] d;
        d = s[11] ? s - jom_pkg::MID_CODE : jom_pkg::MID_CODE - s;
        return d > ovr_thresh;
    endfunction : ovf

    // Offers one frame and notes the lanes it must produce.
    task automatic frame(input int m, input bit edge_on);
        jom_tb_exp_s e;
        int k, n, p;
        logic [11:0] sa, sb;
        logic [47:0] wa, wb;
        logic [7:0] fa, fb;
        @(negedge clk);
        k = mt[m][1];
        n = mt[m][2];
        link_mode_code = 7'(mt[m][0]);
        frame_valid = 1'b1;
        for (int i = 0; i < 16; i++) samp[i] = 12'($urandom);
        ovr_thresh = 12'h100 + 12'($urandom % 1024);
        for (int i = 0; i < 8; i++) begin
            i_word[i] = 15'($urandom);
            q_word[i] = 15'($urandom);
            sa = ovr_thresh + 12'(i % 2);
            ovr_samp_a[i] = (i & 2) ? jom_pkg::MID_CODE - sa
                                    : jom_pkg::MID_CODE + sa;
            ovr_samp_b[i] = (i & 4) ? jom_pkg::MID_CODE - sa
                                    : jom_pkg::MID_CODE + sa;
            if (!edge_on) ovr_samp_a[i] = 12'($urandom);
            if (!edge_on) ovr_samp_b[i] = 12'($urandom);
            // Full-scale low code, so the low-code overrange case is reached.
            if (!edge_on && i == 0 && samp[0][0]) ovr_samp_a[0] = 12'h000;
            fa[i] = ovf(ovr_samp_a[i]);
            fb[i] = ovf(ovr_samp_b[i]);
        end
        e = '0;
        e.st = {1'b1, 4'(n), jom_pkg::OCT_TWO, 1'b0};
        e.rx = (k == 1);
        case (k)
            0: e.st = 8'h01;
            1, 2: for (int g = 0; g < n / 3; g++) begin
                for (int j = 0; j < 4; j++) begin
                    p = 4 * g + j;
                    sa = (k == 1) ? samp[2 * p] : samp[p];
                    sb = (k == 1) ? samp[2 * p + 1] : samp[8 + p];
                    wa = {wa[35:0], sa};
                    wb = {wb[35:0], sb};
                    e.s[2 * p] = sa;
                    e.s[2 * p + 1] = sb;
                end
                {e.a[3 * g], e.a[3 * g + 1], e.a[3 * g + 2]} = wa;
                {e.b[3 * g], e.b[3 * g + 1], e.b[3 * g + 2]} = wb;
            end
            3, 4: begin
                e.st[2:1] = jom_pkg::OCT_ONE;
                for (int j = 0; j < 2; j++) begin
                    sa = (k == 3) ? samp[2 * j] : samp[j];
                    sb = (k == 3) ? samp[2 * j + 1] : samp[8 + j];
                    e.a[j] = {sa[11:4], 8'h00};
                    e.b[j] = {sb[11:4], 8'h00};
                end
            end
            5, 7: for (int j = 0; j < n; j++) begin
                e.a[j] = {i_word[j], fa[(k == 7) ? j / 2 : j]};
                e.b[j] = {q_word[j], fb[(k == 7) ? j / 2 : j]};
            end
            default: begin
                e.a[0] = {i_word[0], fa[0]};
                e.a[1] = {q_word[0], fa[1]};
                e.b[0] = {i_word[1], fb[0]};
                e.b[1] = {q_word[1], fb[1]};
            end
        endcase
        exp_q.push_back(e);
    endtask : frame

    task automatic idle(input int c);
        repeat (c) begin
            @(negedge clk);
            frame_valid = 1'b0;
        end
    endtask : idle

    // Holds reset eight cycles, then checks every output's reset value.
    task automatic rst_chk();
        @(negedge clk);
        rstn = 1'b0;
        frame_valid = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        cmp_lanes(link_a_lane, '0);
        cmp_lanes(link_b_lane, '0);
        cmp_stat({lane_valid, lanes_used, octets_per_lane, mode_bad},
                 8'h04);
    endtask : rst_chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // A result is due one cycle after each taken frame, else no valid.
    always @(posedge clk) fv_d <= frame_valid && rstn;
    always @(negedge clk) begin
        jom_tb_exp_s e;
        if (fv_d === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_lanes(link_a_lane, e.a);
            cmp_lanes(link_b_lane, e.b);
            cmp_stat({lane_valid, lanes_used, octets_per_lane, mode_bad}
                     & (e.st[7] ? 8'hFF : 8'h81), e.st);
            if (e.rx) cmp_samp(rx_samp, e.s);
        end else if (rstn === 1'b1) begin
            cmp_stat({7'h00, lane_valid}, 8'h00);
        end
    end

    // The run takes some 490 cycles, so 4000 can only mean a hang.
    initial begin
        #(8 * 4000);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        n_mismatch = 0;
        n_checks = 0;
        rstn = 1'b0;
        frame_valid = 1'b0;
        link_mode_code = '0;
        samp = '0;
        i_word = '0;
        q_word = '0;
        ovr_samp_a = '0;
        ovr_samp_b = '0;
        ovr_thresh = '0;
        void'($urandom(49578));
        rst_chk();
        $display("test reset done");
        for (int m = 0; m < 32; m++) frame(m, 1'b0);
        idle(2);
        $display("test all_modes done");
        for (int m = 0; m < 32; m++) frame(m, 1'b1);
        idle(2);
        $display("test overrange_edges done");
        repeat (300) begin
            frame($urandom % 32, $urandom % 2);
            if ($urandom % 3 == 0) idle(1);
        end
        rst_chk();
        $display("test random_and_reset done");
        wrap_up();
    end
endmodule : tb
